// ==== core/blc_pkg.sv ====
// Package for the break-point lineariser calibration block
`default_nettype none
package blc_pkg;
	// Table size and field widths
	localparam int unsigned MAX_POINTS = 17;
	localparam int unsigned IDX_W = 5;
	localparam int unsigned CUR_W = 16;
	localparam int unsigned DISP_W = 20;
	localparam logic [4:0] MIN_POINTS = 5'h02;
	localparam logic [4:0] FULL_POINTS = 5'h11;
	// Current limits in microamps: 3.8 mA and 21.0 mA
	localparam logic [15:0] CUR_LOW_UA = 16'h0ed8;
	localparam logic [15:0] CUR_HIGH_UA = 16'h5208;
	// Default table: 4 mA shows 0.0, 20 mA shows 100.0
	localparam logic [15:0] DEF_CUR0 = 16'h0fa0;
	localparam logic [15:0] DEF_CUR1 = 16'h4e20;
	localparam logic [19:0] DEF_DISP0 = 20'h00000;
	localparam logic [19:0] DEF_DISP1 = 20'h003e8;
	// Submenu prompt codes
	localparam logic [1:0] MENU_ADD = 2'h0;
	localparam logic [1:0] MENU_REMOVE = 2'h1;
	localparam logic [1:0] MENU_SET = 2'h2;
	localparam logic [1:0] MENU_VALUE = 2'h3;
	// Function states, one-hot
	typedef enum logic [6:0] {
		FN_MENU = 7'h01,
		FN_ADD_POINT = 7'h02,
		FN_REMOVE_POINT = 7'h04,
		FN_SET_POINTS = 7'h08,
		FN_SOURCE_VALUE = 7'h10,
		FN_REF_CURRENT = 7'h20,
		FN_VALUE_ENTRY = 7'h40
	} blc_fn_t;
	// Front-panel inputs
	typedef struct packed {
		logic up;
		logic down;
		logic confirm;
		logic leave;
		logic restore;
		logic refPath;
	} blc_btn_t;
	// One break-point
	typedef struct packed {
		logic [15:0] current;
		logic [19:0] display;
	} blc_point_t;
endpackage : blc_pkg
`default_nettype wire

// ==== core/blc_lineariser.sv ====
// Break-point lineariser calibration core
// Operation
// RQ1: add inserts ahead of selection, renumbers later
// RQ2: delete removes selection, later indices drop
// RQ3: each confirm in delete removes one
// RQ4: never fewer than two break-points
// RQ5: current strictly ordered, within 3.8-21.0 mA
// RQ6: ordering fault raises error indication
// RQ7: faulty change discarded, table kept
// RQ8: add/delete shows index and count
// RQ9: submenu prompt follows last used function
// RQ10: point setting starts at index zero
// RQ11: source path captures live loop current
// RQ12: operator applies exact current before capture
// RQ13: reference path has four sub-functions
// RQ14: reference path takes numeric current entry
// RQ15: reference path ignores actual loop current
// RQ16: operator inserts before highest point
// RQ17: up to seventeen break-points
// RQ18: extrapolate with end segment slopes
// RQ19: display interpolates bracketing break-points
`default_nettype none
module blc_lineariser
	import blc_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Front-panel pins
	input wire blc_btn_t panelPins,
	// Same-clock values: loop current and digit editor
	input wire logic [15:0] loopCurrent,
	input wire logic [15:0] entryCurrent,
	input wire logic [19:0] entryDisplay,
	// Status
	output blc_fn_t fnState_reg,
	output logic [4:0] selIndex_reg,
	output logic [4:0] pointCount_reg,
	output logic showPoint_reg,
	output logic orderError_reg,
	output logic [1:0] menuPrompt_reg,
	output logic [19:0] displayValue_reg
);
	blc_btn_t syncA_reg;
	blc_btn_t syncB_reg;
	blc_btn_t prev_reg;
	blc_point_t pt_reg [MAX_POINTS];
	blc_fn_t fn_next;
	logic [4:0] sel_next;
	logic [4:0] lastIdx;
	logic pUp, pDown, pOk, pLeave, pRestore, anyPress;
	logic inMenu, inPoints, writeReq, curOk, loOk, hiOk;
	logic doInsert, doRemove, doWriteCur, doWriteDisp;
	logic [15:0] newCur;
	logic [1:0] menuMax;
	logic [4:0] seg;
	logic [19:0] interp;

	// Two-stage synchroniser and edge memory
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			syncA_reg <= '0;
			syncB_reg <= '0;
			prev_reg <= '0;
		end else begin
			syncA_reg <= panelPins;
			syncB_reg <= syncA_reg;
			prev_reg <= syncB_reg;
		end
	end

	// Press pulses from synchronised levels
	assign pUp = syncB_reg.up && !prev_reg.up;
	assign pDown = syncB_reg.down && !prev_reg.down;
	assign pOk = syncB_reg.confirm && !prev_reg.confirm;
	assign pLeave = syncB_reg.leave && !prev_reg.leave;
	assign pRestore = syncB_reg.restore && !prev_reg.restore;
	assign anyPress = pUp || pDown || pOk || pLeave;

	// Mode decode
	assign inMenu = (fnState_reg == FN_MENU);
	assign inPoints = !inMenu && (fnState_reg != FN_SOURCE_VALUE);
	assign lastIdx = pointCount_reg - 5'h01;
	assign menuMax = syncB_reg.refPath ? MENU_VALUE : MENU_SET; // see RQ13

	// Current source: live loop or numeric entry
	assign newCur = (fnState_reg == FN_SET_POINTS) ? loopCurrent : entryCurrent; // see RQ11 see RQ14 see RQ15
	assign writeReq = pOk && ((fnState_reg == FN_SET_POINTS) || (fnState_reg == FN_REF_CURRENT));

	// Order and range check against neighbours
	assign loOk = (selIndex_reg == 5'h00) || (newCur > pt_reg[selIndex_reg - 5'h01].current); // see RQ5
	assign hiOk = (selIndex_reg == lastIdx) || (newCur < pt_reg[selIndex_reg + 5'h01].current); // see RQ5
	assign curOk = loOk && hiOk && (newCur >= CUR_LOW_UA) && (newCur <= CUR_HIGH_UA); // see RQ5

	// Table edit strobes
	assign doInsert = pOk && (fnState_reg == FN_ADD_POINT) && (pointCount_reg < FULL_POINTS); // see RQ1 see RQ17
	assign doRemove = pOk && (fnState_reg == FN_REMOVE_POINT) && (pointCount_reg > MIN_POINTS); // see RQ3 see RQ4
	assign doWriteCur = writeReq && curOk; // see RQ7
	assign doWriteDisp = pOk && ((fnState_reg == FN_SOURCE_VALUE) || (fnState_reg == FN_VALUE_ENTRY));

	// Next function state
	always_comb begin
		fn_next = fnState_reg;
		unique case (fnState_reg)
			FN_MENU: begin
				if (pOk) begin
					unique case (menuPrompt_reg)
						MENU_ADD: fn_next = FN_ADD_POINT;
						MENU_REMOVE: fn_next = FN_REMOVE_POINT;
						MENU_SET: fn_next = syncB_reg.refPath ? FN_REF_CURRENT : FN_SET_POINTS;
						MENU_VALUE: fn_next = FN_VALUE_ENTRY;
					endcase
				end
			end
			FN_SET_POINTS: begin
				if (pLeave) fn_next = FN_MENU;
				else if (doWriteCur) fn_next = FN_SOURCE_VALUE; // see RQ11
			end
			FN_SOURCE_VALUE: begin
				if (pOk || pLeave) fn_next = FN_SET_POINTS;
			end
			FN_ADD_POINT, FN_REMOVE_POINT, FN_REF_CURRENT, FN_VALUE_ENTRY: begin
				if (pLeave) fn_next = FN_MENU;
			end
			default: fn_next = FN_MENU;
		endcase
		if (pRestore) fn_next = FN_MENU;
	end

	// Next selection
	always_comb begin
		sel_next = selIndex_reg;
		if (inMenu && pOk) sel_next = 5'h00; // see RQ10
		else if (inPoints && pUp && selIndex_reg < lastIdx) sel_next = selIndex_reg + 5'h01;
		else if (inPoints && pDown && selIndex_reg != 5'h00) sel_next = selIndex_reg - 5'h01;
		else if (doRemove && selIndex_reg == lastIdx) sel_next = selIndex_reg - 5'h01;
		if (pRestore) sel_next = 5'h00;
	end

	// Control registers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			fnState_reg <= FN_MENU;
			selIndex_reg <= 5'h00;
			pointCount_reg <= MIN_POINTS;
			showPoint_reg <= 1'b0;
			orderError_reg <= 1'b0;
			menuPrompt_reg <= MENU_ADD;
		end else begin
			fnState_reg <= fn_next;
			selIndex_reg <= sel_next;
			if (pRestore) pointCount_reg <= MIN_POINTS;
			else if (doInsert) pointCount_reg <= pointCount_reg + 5'h01; // see RQ1
			else if (doRemove) pointCount_reg <= pointCount_reg - 5'h01; // see RQ2
			showPoint_reg <= (fn_next != FN_MENU); // see RQ8
			if (writeReq && !curOk) orderError_reg <= 1'b1; // see RQ6
			else if (anyPress || pRestore) orderError_reg <= 1'b0;
			if (inMenu && pUp && menuPrompt_reg < menuMax) menuPrompt_reg <= menuPrompt_reg + 2'h1;
			else if (inMenu && pDown && menuPrompt_reg != MENU_ADD) menuPrompt_reg <= menuPrompt_reg - 2'h1;
			else if (inMenu && menuPrompt_reg > menuMax) menuPrompt_reg <= menuMax;
			else if (pLeave && fnState_reg == FN_REMOVE_POINT) menuPrompt_reg <= MENU_REMOVE; // see RQ9
			else if (pLeave && fnState_reg == FN_ADD_POINT) menuPrompt_reg <= MENU_ADD; // see RQ9
		end
	end

	// Break-point table
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < MAX_POINTS; i++) pt_reg[i] <= '0;
			pt_reg[0] <= '{current: DEF_CUR0, display: DEF_DISP0};
			pt_reg[1] <= '{current: DEF_CUR1, display: DEF_DISP1};
		end else if (pRestore) begin
			pt_reg[0] <= '{current: DEF_CUR0, display: DEF_DISP0};
			pt_reg[1] <= '{current: DEF_CUR1, display: DEF_DISP1};
		end else begin
			for (int i = 1; i < MAX_POINTS; i++) begin
				if (doInsert && 5'(i) > selIndex_reg) pt_reg[i] <= pt_reg[i - 1]; // see RQ1
			end
			for (int i = 0; i < MAX_POINTS - 1; i++) begin
				if (doRemove && 5'(i) >= selIndex_reg) pt_reg[i] <= pt_reg[i + 1]; // see RQ2
			end
			if (doWriteCur) pt_reg[selIndex_reg].current <= newCur; // see RQ7 see RQ11
			if (doWriteDisp) pt_reg[selIndex_reg].display <= entryDisplay;
		end
	end

	// Segment search: end segments extend past the table
	always_comb begin
		seg = 5'h00;
		for (int i = 1; i < MAX_POINTS - 1; i++) begin
			if (5'(i) < lastIdx && pt_reg[i].current <= loopCurrent) seg = 5'(i); // see RQ18
		end
	end

	// Linear interpolation within the chosen segment
	logic signed [16:0] dx, span;
	logic signed [20:0] dy;
	logic signed [37:0] prod, quot;
	assign dx = signed'({1'b0, loopCurrent}) - signed'({1'b0, pt_reg[seg].current});
	assign span = signed'({1'b0, pt_reg[seg + 5'h01].current}) - signed'({1'b0, pt_reg[seg].current});
	assign dy = signed'({pt_reg[seg + 5'h01].display[19], pt_reg[seg + 5'h01].display})
		- signed'({pt_reg[seg].display[19], pt_reg[seg].display});
	// Widen both factors first so the product keeps all its bits
	assign prod = 38'(dx) * 38'(dy);
	assign quot = (span > 17'sd0) ? prod / 38'(span) : 38'sd0; // Misordered table holds first value
	assign interp = pt_reg[seg].display + quot[19:0]; // see RQ19

	// Registered display output
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) displayValue_reg <= '0;
		else displayValue_reg <= interp; // see RQ18 see RQ19
	end

	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// Restore overrides every edit, so the edit checks leave it out
	// Table growth
	a_add_count: assert property (doInsert && !pRestore // see RQ1
		|=> pointCount_reg == $past(pointCount_reg) + 5'h01)
		else $error("add did not grow the table");
	a_add_shift: assert property (doInsert && !pRestore // see RQ1
		|=> pt_reg[$past(selIndex_reg) + 5'h01] == $past(pt_reg[selIndex_reg]))
		else $error("add did not shift later points");
	a_full_refuse: assert property (pOk && fnState_reg == FN_ADD_POINT && !pRestore // see RQ17
		&& pointCount_reg == FULL_POINTS |=> pointCount_reg == FULL_POINTS)
		else $error("add went past the table size");

	// Table shrink and floor
	a_remove_count: assert property (doRemove && !pRestore // see RQ2
		|=> pointCount_reg == $past(pointCount_reg) - 5'h01)
		else $error("remove did not shrink the table");
	a_remove_shift: assert property (doRemove && !pRestore && selIndex_reg < lastIdx // see RQ2
		|=> pt_reg[$past(selIndex_reg)] == $past(pt_reg[selIndex_reg + 5'h01]))
		else $error("remove did not shift later points");
	a_remove_each: assert property (fnState_reg == FN_REMOVE_POINT && pOk && !pRestore // see RQ3
		&& pointCount_reg > MIN_POINTS |=> pointCount_reg == $past(pointCount_reg) - 5'h01)
		else $error("confirm in remove removed nothing");
	a_count_range: assert property (pointCount_reg >= MIN_POINTS // see RQ4
		&& pointCount_reg <= FULL_POINTS)
		else $error("point count out of range");
	a_floor_refuse: assert property (pOk && fnState_reg == FN_REMOVE_POINT && !pRestore // see RQ4
		&& pointCount_reg == MIN_POINTS |=> pointCount_reg == MIN_POINTS)
		else $error("remove went below two points");

	// Current writes: range, order, fault handling
	a_cur_range: assert property (doWriteCur && !pRestore // see RQ5
		|=> pt_reg[$past(selIndex_reg)].current >= CUR_LOW_UA && pt_reg[$past(selIndex_reg)].current <= CUR_HIGH_UA)
		else $error("current written outside limits");
	a_cur_order: assert property (doWriteCur && !pRestore && selIndex_reg != 5'h00 // see RQ5
		|=> pt_reg[$past(selIndex_reg)].current > pt_reg[$past(selIndex_reg) - 5'h01].current)
		else $error("current written out of order");
	a_order_flag: assert property (writeReq && !curOk // see RQ6
		|=> orderError_reg)
		else $error("ordering fault not flagged");
	a_order_keep: assert property (writeReq && !curOk && !pRestore // see RQ7
		|=> pt_reg[$past(selIndex_reg)] == $past(pt_reg[selIndex_reg]))
		else $error("faulty change altered table");

	// Index display and submenu prompt
	a_show_point: assert property (fnState_reg inside {FN_ADD_POINT, FN_REMOVE_POINT} // see RQ8
		|-> showPoint_reg)
		else $error("index not shown in add or remove");
	a_prompt_last: assert property (pLeave && fnState_reg == FN_REMOVE_POINT // see RQ9
		|=> menuPrompt_reg == MENU_REMOVE)
		else $error("prompt does not follow last function");
	a_prompt_add: assert property (pLeave && fnState_reg == FN_ADD_POINT // see RQ9
		|=> menuPrompt_reg == MENU_ADD)
		else $error("prompt does not follow add");

	// Selection and calibration paths
	a_enter_zero: assert property (inMenu && pOk // see RQ10
		|=> selIndex_reg == 5'h00)
		else $error("entry did not select point zero");
	a_sel_bound: assert property (fnState_reg != FN_MENU // see RQ10
		|-> selIndex_reg < pointCount_reg)
		else $error("selection beyond the table");
	a_capture_loop: assert property (fnState_reg == FN_SET_POINTS && doWriteCur && !pRestore // see RQ11
		|=> pt_reg[$past(selIndex_reg)].current == $past(loopCurrent))
		else $error("loop current not captured");
	a_ref_path: assert property (inMenu && pOk && !pRestore && syncB_reg.refPath // see RQ13
		&& menuPrompt_reg == MENU_SET |=> fnState_reg == FN_REF_CURRENT)
		else $error("reference path did not open current entry");
	a_ref_entry: assert property (fnState_reg == FN_REF_CURRENT && doWriteCur && !pRestore // see RQ14
		|=> pt_reg[$past(selIndex_reg)].current == $past(entryCurrent))
		else $error("entered current not stored");

	// End segments extend past the table
	a_seg_low: assert property (loopCurrent < pt_reg[1].current // see RQ18
		|-> seg == 5'h00)
		else $error("low input not on first segment");
	a_seg_high: assert property (loopCurrent >= pt_reg[lastIdx].current // see RQ18
		|-> seg == lastIdx - 5'h01)
		else $error("high input not on last segment");

	// Main scenarios
	c_insert: cover property (doInsert);
	c_remove: cover property (doRemove);
	c_order_fault: cover property (writeReq && !curOk);
	c_ref_entry: cover property (fnState_reg == FN_REF_CURRENT && doWriteCur);
	c_value_entry: cover property (fnState_reg == FN_VALUE_ENTRY && doWriteDisp);
endmodule : blc_lineariser
`default_nettype wire

// ==== sim/blc_panel_model.sv ====
// Push-button and loop-current model facing the lineariser core
`default_nettype none
module blc_panel_model
	import blc_pkg::*;
(
	// Clock
	input wire logic sys_clk,
	// Panel pins and measured loop current
	output blc_btn_t panelPins,
	output logic [15:0] loopCurrent
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle: nothing pressed, loop at 12 mA
	initial begin
		panelPins = blc_btn_t'(6'h00);
		loopCurrent = 16'h2ee0;
	end
	// Held long enough to act, then low long enough to re-arm the edge detect
	task automatic press(input logic [5:0] m);
		@(negedge sys_clk) panelPins = blc_btn_t'(panelPins | m);
		repeat (4) @(negedge sys_clk);
		panelPins = blc_btn_t'(panelPins & ~m);
		repeat (3) @(negedge sys_clk);
	endtask : press
	// Exact loop current is applied before any capture
	task automatic setLoop(input logic [15:0] v);
		@(negedge sys_clk) loopCurrent = v;
		repeat (3) @(negedge sys_clk);
	endtask : setLoop
	// Calibration path level
	task automatic setPath(input logic r);
		@(negedge sys_clk) panelPins.refPath = r;
	endtask : setPath
endmodule : blc_panel_model
`default_nettype wire

// ==== sim/blc_lineariser_tb_top.sv ====
// Self-checking bench for the break-point lineariser core
`default_nettype none
module blc_lineariser_tb_top
	import blc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	blc_btn_t panelPins;
	logic [15:0] loopCurrent;
	logic [15:0] entryCurrent = 16'h0fa0;
	logic [19:0] entryDisplay = 20'h00000;
	blc_fn_t fnState_reg;
	logic [4:0] selIndex_reg;
	logic [4:0] pointCount_reg;
	logic showPoint_reg;
	logic orderError_reg;
	logic [1:0] menuPrompt_reg;
	logic [19:0] displayValue_reg;
	int failures = 0;
	int comparisons = 0;
	localparam logic [5:0] UP = 6'h20;
	localparam logic [5:0] CONF = 6'h08;
	localparam logic [5:0] LEAVE = 6'h04;
	localparam logic [5:0] DOWN = 6'h10;
	localparam logic [5:0] RESTORE = 6'h02;
	// 10 MHz clock
	always #50 sys_clk = ~sys_clk;
	// Core and its panel
	blc_lineariser u_blc_lineariser(.sys_clk(sys_clk), .rst(rst), .panelPins(panelPins),
		.loopCurrent(loopCurrent), .entryCurrent(entryCurrent), .entryDisplay(entryDisplay),
		.fnState_reg(fnState_reg), .selIndex_reg(selIndex_reg), .pointCount_reg(pointCount_reg),
		.showPoint_reg(showPoint_reg), .orderError_reg(orderError_reg),
		.menuPrompt_reg(menuPrompt_reg), .displayValue_reg(displayValue_reg));
	blc_panel_model u_blc_panel_model(.sys_clk(sys_clk), .panelPins(panelPins), .loopCurrent(loopCurrent));
	// Compare and count
	task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Counts, verdict, end of run
	task automatic wrap_up();
		$display("Counts: %0d mismatches in %0d comparisons", failures, comparisons);
		if (failures == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : wrap_up
	task automatic press(input logic [5:0] m);
		u_blc_panel_model.press(m);
	endtask : press
	// Set loop current, then look at the display
	task automatic loopCheck(input logic [15:0] c, input logic [19:0] e);
		u_blc_panel_model.setLoop(c);
		chk("display", e, displayValue_reg);
	endtask : loopCheck
	// Numeric current entry, then the error level
	task automatic refEntry(input logic [15:0] c, input logic e);
		@(negedge sys_clk) entryCurrent = c;
		press(CONF);
		chk("error", 20'(e), 20'(orderError_reg));
	endtask : refEntry
	// Values after reset
	task automatic resetState();
		chk("state", 20'(FN_MENU), 20'(fnState_reg));
		chk("count", 20'h00002, 20'(pointCount_reg));
		chk("prompt", 20'h00000, 20'(menuPrompt_reg));
		chk("error", 20'h00000, 20'(orderError_reg));
		chk("show", 20'h00000, 20'(showPoint_reg));
	endtask : resetState
	// Default table: inside and beyond both ends
	task automatic interpolation();
		loopCheck(16'h2ee0, 20'h001f4);
		loopCheck(16'h07d0, 20'hfff83);
		loopCheck(16'h55f0, 20'h00465);
	endtask : interpolation
	// Fill the table ahead of the highest point until refused
	task automatic addPoints();
		press(CONF);
		chk("state", 20'(FN_ADD_POINT), 20'(fnState_reg));
		chk("show", 20'h00001, 20'(showPoint_reg));
		chk("index", 20'h00000, 20'(selIndex_reg));
		for (int i = 0; i < 15; i++) begin
			press(UP);
			press(CONF);
			chk("count", 20'(i + 3), 20'(pointCount_reg));
			chk("index", 20'(i + 1), 20'(selIndex_reg));
		end
		press(UP);
		press(CONF);
		chk("count", 20'h00011, 20'(pointCount_reg));
		press(LEAVE);
		chk("prompt", 20'h00000, 20'(menuPrompt_reg));
		loopCheck(16'h2ee0, 20'h001f4);
	endtask : addPoints
	// Remove down to the floor and one more
	task automatic removePoints();
		press(UP);
		press(CONF);
		chk("state", 20'(FN_REMOVE_POINT), 20'(fnState_reg));
		chk("count", 20'h00011, 20'(pointCount_reg));
		press(UP);
		for (int i = 0; i < 16; i++) begin
			press(CONF);
			chk("count", 20'(i < 15 ? 16 - i : 2), 20'(pointCount_reg));
		end
		chk("index", 20'h00001, 20'(selIndex_reg));
		press(LEAVE);
		chk("prompt", 20'h00001, 20'(menuPrompt_reg));
		loopCheck(16'h2ee0, 20'h001f4);
	endtask : removePoints
	// Capture the live loop current into point 1
	task automatic sourceCal();
		press(UP);
		press(CONF);
		chk("state", 20'(FN_SET_POINTS), 20'(fnState_reg));
		chk("index", 20'h00000, 20'(selIndex_reg));
		press(UP);
		u_blc_panel_model.setLoop(16'h5208);
		press(CONF);
		chk("state", 20'(FN_SOURCE_VALUE), 20'(fnState_reg));
		@(negedge sys_clk) entryDisplay = 20'h007d0;
		press(CONF);
		press(LEAVE);
		chk("state", 20'(FN_MENU), 20'(fnState_reg));
		loopCheck(16'h30d4, 20'h003e8);
	endtask : sourceCal
	// Numeric entry: range fault, order fault, then a good value
	task automatic referenceCal();
		u_blc_panel_model.setPath(1'b1);
		press(CONF);
		chk("state", 20'(FN_REF_CURRENT), 20'(fnState_reg));
		refEntry(16'h0ed7, 1'b1);
		refEntry(16'h5208, 1'b1);
		loopCheck(16'h30d4, 20'h003e8);
		refEntry(16'h2ee0, 1'b0);
		loopCheck(16'h4074, 20'h003e8);
	endtask : referenceCal
	// Display entry on the reference path, then the default restore
	task automatic valueRestore();
		press(LEAVE);
		press(UP);
		chk("prompt", 20'h00003, 20'(menuPrompt_reg));
		press(CONF);
		chk("state", 20'(FN_VALUE_ENTRY), 20'(fnState_reg));
		press(UP);
		press(DOWN);
		chk("index", 20'h00000, 20'(selIndex_reg));
		@(negedge sys_clk) entryDisplay = 20'h00064;
		press(CONF);
		loopCheck(16'h4074, 20'h0041a);
		press(RESTORE);
		chk("state", 20'(FN_MENU), 20'(fnState_reg));
		chk("count", 20'h00002, 20'(pointCount_reg));
		chk("show", 20'h00000, 20'(showPoint_reg));
		loopCheck(16'h2ee0, 20'h001f4);
	endtask : valueRestore
	// Main sequence
	initial begin
		repeat (12) @(negedge sys_clk);
		rst = 1'b0;
		resetState();
		interpolation();
		addPoints();
		removePoints();
		sourceCal();
		referenceCal();
		valueRestore();
		wrap_up();
	end
	// Watchdog well beyond the expected run
	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		wrap_up();
	end
endmodule : blc_lineariser_tb_top
`default_nettype wire
